// file: rtl/dor_pkg.sv
package dor_pkg;
	// register port
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam logic [7:0]  OFS_CMD    = 8'h00;
	localparam logic [7:0]  OFS_POL    = 8'h04;
	localparam logic [7:0]  OFS_FEN    = 8'h08;
	localparam logic [7:0]  OFS_FVAL   = 8'h0C;
	localparam logic [7:0]  OFS_APPL   = 8'h10;
	localparam logic [7:0]  OFS_RTEN   = 8'h14;
	localparam logic [7:0]  OFS_LED    = 8'h18;
	localparam logic [7:0]  OFS_ROUTE  = 8'h40;
	localparam logic [7:0]  ROUTE_STEP = 8'h04;

	// command word layout
	localparam int unsigned OUT_BIT_BASE = 16;
	localparam int unsigned BRAKE_BIT    = 0;
	localparam int unsigned RTEN_BIT     = 0;
	localparam int unsigned LED_GREEN    = 0;
	localparam int unsigned LED_RED      = 1;

	// routing entry layout
	localparam int unsigned SRC_LSB      = 8;
	localparam int unsigned INV_BIT      = 7;
	localparam logic [15:0] ROUTE_OFF    = 16'hFFFF;
	localparam logic [7:0]  SRC_ONE      = 8'h00;
	localparam logic [7:0]  SRC_ZERO     = 8'h01;
	localparam logic [7:0]  SRC_ENC1     = 8'h02;
	localparam logic [7:0]  SRC_ENC64    = 8'h08;
	localparam logic [7:0]  SRC_POS1     = 8'h09;
	localparam logic [7:0]  SRC_POS64    = 8'h0F;
	localparam logic [7:0]  SRC_PWM      = 8'h10;
	localparam logic [7:0]  SRC_PWM_N    = 8'h11;

	// reset values
	localparam logic [31:0] WORD_RST     = 32'h0000_0000;

	// timing
	localparam int unsigned CLK_KHZ       = 200000;
	localparam int unsigned LED_HALF_MS   = 250;
	localparam int unsigned LED_HALF_CYC  = LED_HALF_MS * CLK_KHZ;
	localparam int unsigned SWPWM_HALF_US = 250;
	localparam int unsigned SWPWM_HALF_CYC =
		(SWPWM_HALF_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned OUT_HALF_US   = 1000;
	localparam int unsigned OUT_HALF_CYC  =
		(OUT_HALF_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned CNT_W         = 27;
endpackage : dor_pkg

// file: rtl/dor_top.sv
module dor_top
	import dor_pkg::*;
#(
	parameter int unsigned N_OUT      = 2,
	parameter int unsigned LED_HALF   = LED_HALF_CYC,
	parameter int unsigned SWPWM_HALF = SWPWM_HALF_CYC,
	parameter int unsigned OUT_HALF   = OUT_HALF_CYC
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	// motion events
	input  wire logic              enc_step_i,
	input  wire logic              pos_step_i,
	input  wire logic              brake_pwm_i,
	input  wire logic              fault_i,
	// outputs
	output logic      [N_OUT-1:0]  out_o,
	output logic      [N_OUT-1:0]  out_oe_o,
	output logic                   brake_o,
	output logic                   swpwm_o,
	output logic                   led_green_o,
	output logic                   led_red_o
);
	localparam int unsigned N_ROUTE = N_OUT + 1;

	logic [31:0] cmd_reg;
	logic [31:0] pol_reg;
	logic [31:0] fen_reg;
	logic [31:0] fval_reg;
	logic        rten_reg;
	logic [1:0]  led_reg;
	logic [15:0] route_tab_reg [N_ROUTE];
	logic [31:0] applied;
	logic [N_ROUTE-1:0] routed;
	logic [N_ROUTE-1:0] ent_wr;
	logic [5:0]  ridx;
	logic        in_route;
	logic [N_OUT-1:0] out_next;
	logic        brake_next;
	logic        swpwm_next;
	logic [CNT_W-1:0] led_cnt_reg;
	logic        blink_reg;
	logic [31:0] rdata_next;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// routing table decode
	assign ridx     = 6'(addr_i[ADDR_W-1:2] - OFS_ROUTE[7:2]);
	assign in_route = (addr_i >= OFS_ROUTE) && (addr_i[1:0] == 2'h0)
		&& (32'(ridx) < N_ROUTE);

	always_comb begin
		ent_wr = '0;
		for (int i = 0; i < N_ROUTE; i++) begin
			ent_wr[i] = wr_i && in_route && (32'(ridx) == i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_reg  <= WORD_RST;
			pol_reg  <= WORD_RST;
			fen_reg  <= WORD_RST;
			fval_reg <= WORD_RST;
			rten_reg <= 1'b0;
			led_reg  <= 2'h0;
		end else if (wr_i) begin
			case (addr_i)
				OFS_CMD:  cmd_reg  <= wdata_i;
				OFS_POL:  pol_reg  <= wdata_i;
				OFS_FEN:  fen_reg  <= wdata_i;
				OFS_FVAL: fval_reg <= wdata_i;
				OFS_RTEN: rten_reg <= wdata_i[RTEN_BIT];
				OFS_LED:  led_reg  <= wdata_i[1:0];
				default:  ;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < N_ROUTE; i++) begin
				route_tab_reg[i] <= ROUTE_OFF;
			end
		end else begin
			for (int i = 0; i < N_ROUTE; i++) begin
				if (ent_wr[i]) begin
					route_tab_reg[i] <= wdata_i[15:0];
				end
			end
		end
	end

	// entry 0 feeds software PWM, entry n output n
	for (genvar g = 0; g < N_ROUTE; g++) begin : g_route
		localparam int unsigned HALF = (g == 0) ? SWPWM_HALF : OUT_HALF;
		logic [15:0]      ent;
		logic [7:0]       src;
		logic             step;
		logic [2:0]       k;
		logic [5:0]       mask;
		logic             ev;
		logic [5:0]       psc_reg;
		logic [CNT_W-1:0] hold_reg;
		logic             pulse;
		logic             val;
		logic             gate;

		// high byte source, low byte gating bit
		assign ent = route_tab_reg[g];
		assign src = ent[15:SRC_LSB];

		always_comb begin
			step = 1'b0;
			k    = 3'h0;
			if (src >= SRC_ENC1 && src <= SRC_ENC64) begin
				step = enc_step_i;
				k    = 3'(src - SRC_ENC1);
			end else if (src >= SRC_POS1 && src <= SRC_POS64) begin
				step = pos_step_i;
				k    = 3'(src - SRC_POS1);
			end
		end

		// divide by two to the k
		assign mask = ~(6'h3F << k);
		assign ev   = step && ((psc_reg & mask) == mask);

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				psc_reg <= 6'h00;
			end else if (ent_wr[g]) begin
				psc_reg <= 6'h00;
			end else if (step) begin
				psc_reg <= psc_reg + 6'h01;
			end
		end

		// pulse high one half period, then low one
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				hold_reg <= '0;
			end else if (ent_wr[g]) begin
				hold_reg <= '0;
			end else if (hold_reg != '0) begin
				hold_reg <= hold_reg - CNT_W'(1);
			end else if (ev) begin
				hold_reg <= CNT_W'(2 * HALF - 1);
			end
		end
		assign pulse = (hold_reg >= CNT_W'(HALF));

		always_comb begin
			unique case (src) inside
				SRC_ONE:               val = 1'b1;
				SRC_ZERO:              val = 1'b0;
				[SRC_ENC1:SRC_POS64]:  val = pulse;
				SRC_PWM:               val = brake_pwm_i;
				SRC_PWM_N:             val = ~brake_pwm_i;
				default:               val = 1'b0;
			endcase
		end

		assign gate = (ent[6:5] == 2'h0)
			&& (cmd_reg[ent[4:0]] ^ ent[INV_BIT]);

		// all-ones entry holds the output off
		assign routed[g] = (ent != ROUTE_OFF) && gate && val;
	end

	// output resolution
	always_comb begin
		out_next   = '0;
		brake_next = 1'b0;
		swpwm_next = 1'b0;
		if (rten_reg) begin
			// routed outputs bypass polarity and force
			for (int n = 0; n < N_OUT; n++) begin
				out_next[n] = routed[n+1];
			end
			swpwm_next = routed[0];
			brake_next = cmd_reg[BRAKE_BIT];
		end else begin
			for (int n = 0; n < N_OUT; n++) begin
				out_next[n] = fen_reg[OUT_BIT_BASE+n]
					? fval_reg[OUT_BIT_BASE+n]
					: cmd_reg[OUT_BIT_BASE+n] ^ pol_reg[OUT_BIT_BASE+n];
			end
			// brake from bit 0, forcible too
			brake_next = fen_reg[BRAKE_BIT] ? fval_reg[BRAKE_BIT]
				: cmd_reg[BRAKE_BIT] ^ pol_reg[BRAKE_BIT];
		end
	end

	// open drain: enable pulls the pin low
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_o    <= '0;
			out_oe_o <= '1;
			brake_o  <= 1'b0;
			swpwm_o  <= 1'b0;
		end else begin
			out_o    <= out_next;
			out_oe_o <= ~out_next;
			brake_o  <= brake_next;
			swpwm_o  <= swpwm_next;
		end
	end

	// applied pattern taken from the output flops
	always_comb begin
		applied            = '0;
		applied[BRAKE_BIT] = brake_o;
		for (int n = 0; n < N_OUT; n++) begin
			applied[OUT_BIT_BASE+n] = out_o[n];
		end
	end

	// flash divider
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			led_cnt_reg <= '0;
			blink_reg   <= 1'b0;
		end else if (led_cnt_reg == CNT_W'(LED_HALF - 1)) begin
			led_cnt_reg <= '0;
			blink_reg   <= ~blink_reg;
		end else begin
			led_cnt_reg <= led_cnt_reg + CNT_W'(1);
		end
	end

	// green flashes normally, red on fault
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			led_green_o <= 1'b0;
			led_red_o   <= 1'b0;
		end else begin
			led_green_o <= led_reg[LED_GREEN] && !fault_i && blink_reg;
			led_red_o   <= led_reg[LED_RED] && fault_i && blink_reg;
		end
	end

	// read mux, unmapped reads return zero
	always_comb begin
		rdata_next = '0;
		if (in_route) begin
			for (int i = 0; i < N_ROUTE; i++) begin
				if (32'(ridx) == i) begin
					rdata_next = {16'h0000, route_tab_reg[i]};
				end
			end
		end else begin
			case (addr_i)
				OFS_CMD:  rdata_next = cmd_reg;
				OFS_POL:  rdata_next = pol_reg;
				OFS_FEN:  rdata_next = fen_reg;
				OFS_FVAL: rdata_next = fval_reg;
				OFS_APPL: rdata_next = applied;
				OFS_RTEN: rdata_next = {31'h0, rten_reg};
				OFS_LED:  rdata_next = {30'h0, led_reg};
				default:  rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rd_i ? rdata_next : '0;
		end
	end

	property p_cmd_out;
		!rten_reg && !fen_reg[OUT_BIT_BASE] && !pol_reg[OUT_BIT_BASE]
			|=> out_o[0] == $past(cmd_reg[OUT_BIT_BASE]);
	endproperty
	a_cmd_out: assert property (p_cmd_out)
		else $error("output 1 does not follow command bit 16");

	property p_brake;
		!fen_reg[BRAKE_BIT] && !pol_reg[BRAKE_BIT]
			|=> brake_o == $past(cmd_reg[BRAKE_BIT]);
	endproperty
	a_brake: assert property (p_brake)
		else $error("brake does not follow command bit 0");

	property p_polarity;
		!rten_reg && pol_reg[OUT_BIT_BASE] && !fen_reg[OUT_BIT_BASE]
			&& cmd_reg[OUT_BIT_BASE] |=> !out_o[0] && out_oe_o[0];
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("inverted output not driven low");

	property p_force;
		!rten_reg && fen_reg[OUT_BIT_BASE]
			|=> out_o[0] == $past(fval_reg[OUT_BIT_BASE]);
	endproperty
	a_force: assert property (p_force)
		else $error("forced output ignores force value");

	property p_readback;
		rd_i && addr_i == OFS_APPL
			|=> rdata_o[OUT_BIT_BASE] == $past(out_o[0])
			&& rdata_o[BRAKE_BIT] == $past(brake_o);
	endproperty
	a_readback: assert property (p_readback)
		else $error("readback differs from applied outputs");

	property p_led_off;
		!led_reg[LED_GREEN] |=> !led_green_o;
	endproperty
	a_led_off: assert property (p_led_off)
		else $error("green led lit while disabled");

	property p_route_off;
		rten_reg && route_tab_reg[2] == ROUTE_OFF |=> !out_o[1];
	endproperty
	a_route_off: assert property (p_route_off)
		else $error("disabled routing entry drives output");

	property p_const_one;
		rten_reg && route_tab_reg[2][15:8] == SRC_ONE
			&& route_tab_reg[2][7:0] == 8'h80 && !cmd_reg[0]
			|=> out_o[1];
	endproperty
	a_const_one: assert property (p_const_one)
		else $error("constant one source not applied");

	property p_inv_gate;
		rten_reg && route_tab_reg[2] == 16'h0080 && cmd_reg[0]
			|=> !out_o[1];
	endproperty
	a_inv_gate: assert property (p_inv_gate)
		else $error("inverted gate did not switch off");

	sequence s_div1_idle;
		rten_reg && route_tab_reg[1] == 16'h0280 && !cmd_reg[0]
			&& g_route[1].hold_reg == '0;
	endsequence
	sequence s_step_seen;
		enc_step_i;
	endsequence
	property p_div1_pulse;
		s_div1_idle ##0 s_step_seen |=> ##1 out_o[0];
	endproperty
	a_div1_pulse: assert property (p_div1_pulse)
		else $error("no pulse for single encoder step");
endmodule : dor_top

// file: tb/dor_partner.sv
module dor_partner (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// open-drain enables from the outputs
	input  wire logic [1:0] oe_i,
	// brake pwm and pin levels
	output logic            pwm_o,
	output logic      [1:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_reg;
	// free-running brake pwm, half period 8 cycles
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_reg <= 3'h0;
			pwm_o   <= 1'b0;
		end else begin
			div_reg <= div_reg + 3'h1;
			if (div_reg == 3'h7) begin
				pwm_o <= ~pwm_o;
			end
		end
	end
	// external pull-ups win unless pulled low
	assign pin_o = ~oe_i;
endmodule : dor_partner

// file: tb/tb.sv
module tb
	import dor_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NO = 2;
	localparam int OH = 6;
	localparam int SH = 4;
	logic          clk_i, rst_b_i, wr_i, rd_i, enc_step_i, pos_step_i;
	logic          fault_i, brake_o, swpwm_o, led_green_o, led_red_o;
	logic          pwm, bp, o0;
	logic [7:0]    addr_i;
	logic [31:0]   wdata_i, rdata_o, lfsr, cmd, pol, fen, fval, e;
	logic [NO-1:0] out_o, out_oe_o, pin;
	int            num_errors, cmp_count, n, h, hs, g, r;

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	dor_top #(.N_OUT(NO), .LED_HALF(8), .SWPWM_HALF(SH), .OUT_HALF(OH)) DUT (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.enc_step_i(enc_step_i), .pos_step_i(pos_step_i),
		.brake_pwm_i(pwm), .fault_i(fault_i), .out_o(out_o),
		.out_oe_o(out_oe_o), .brake_o(brake_o), .swpwm_o(swpwm_o),
		.led_green_o(led_green_o), .led_red_o(led_red_o)
	);
	dor_partner PARTNER (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.oe_i(out_oe_o), .pwm_o(pwm), .pin_o(pin));

	// pulse and high-time counters
	always @(posedge clk_i) begin
		n += int'(out_o[0] & ~o0);
		h += int'(out_o[0]);
		hs += int'(swpwm_o);
		o0 = out_o[0];
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	// expected applied pattern in normal mode
	function automatic logic [31:0] appl();
		return ((fen & fval) | (~fen & (cmd ^ pol))) & 32'h0003_0001;
	endfunction : appl

	task automatic chk(input logic [31:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got,
				exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, x, "rdata");
	endtask : rd

	task automatic outs();
		repeat (2) @(posedge clk_i);
		#1;
		e = appl();
		chk(32'({out_o, brake_o}), 32'({e[17:16], e[0]}), "out");
		chk(32'(pin), 32'(e[17:16]), "pin");
	endtask : outs

	// one step, then room for a full pulse
	task automatic step(input logic p);
		@(posedge clk_i);
		enc_step_i <= !p;
		pos_step_i <= p;
		@(posedge clk_i);
		enc_step_i <= 1'b0;
		pos_step_i <= 1'b0;
		repeat (14) @(posedge clk_i);
	endtask : step

	task automatic tally_and_finish();
		$display("errors %0d, checks %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#200000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		{wr_i, rd_i, enc_step_i, pos_step_i, fault_i} = 5'h00;
		addr_i = 8'h00;
		wdata_i = 32'h0000_0000;
		lfsr = 32'h0000_1694;
		rst_b_i = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
		for (int i = 0; i < 3; i++) rd(OFS_ROUTE + 8'(4 * i), 32'hFFFF);
		rd(8'h20, 32'h0);
		for (int i = 0; i < 24; i++) begin
			cmd = rnd();
			pol = i < 8 ? 32'h0 : rnd();
			fen = i < 16 ? 32'h0 : rnd();
			fval = rnd();
			wr(OFS_CMD, cmd);
			wr(OFS_POL, pol);
			wr(OFS_FEN, fen);
			wr(OFS_FVAL, fval);
			wr(OFS_APPL, rnd());
			outs();
			rd(OFS_APPL, appl());
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i) fault_i <= i[2];
			wr(OFS_LED, 32'(i[1:0]));
			@(posedge clk_i);
			g = 0;
			r = 0;
			repeat (32) begin
				@(posedge clk_i);
				g += int'(led_green_o);
				r += int'(led_red_o);
			end
			chk(32'(g > 0), 32'(i[0] & !i[2]), "green");
			chk(32'(r > 0), 32'(i[1] & i[2]), "red");
		end
		wr(OFS_POL, 32'hFFFF_FFFF);
		wr(OFS_FEN, 32'hFFFF_FFFF);
		wr(OFS_RTEN, 32'h1);
		for (int i = 0; i < 16; i++) begin
			cmd = rnd();
			e = {16'h0, i[0] ? SRC_ZERO : SRC_ONE, i[1], 2'b00, cmd[20:16]};
			wr(OFS_CMD, cmd);
			wr(OFS_ROUTE + ROUTE_STEP, e);
			wr(OFS_ROUTE + 8'h08, i[3] ? 32'hFFFF : 32'h0080);
			rd(OFS_ROUTE + ROUTE_STEP, e);
			chk(32'(out_o[0]), 32'(!i[0] & (cmd[cmd[20:16]] ^ i[1])), "rt");
			chk(32'(out_o[1]), 32'(!i[3] & !cmd[0]), "rt2");
			chk(32'(brake_o), 32'(cmd[0]), "brake");
		end
		cmd = 32'h0000_0002;
		wr(OFS_CMD, cmd);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_ROUTE, {16'h0, s ? SRC_PWM_N : SRC_PWM, 8'h01});
			repeat (2) @(posedge clk_i);
			repeat (20) begin
				@(posedge clk_i);
				bp = pwm;
				#1 chk(32'(swpwm_o), 32'(bp ^ s[0]), "pwm");
			end
		end
		for (int k = 0; k < 14; k++) begin
			wr(OFS_ROUTE + ROUTE_STEP, {16'h0, SRC_ENC1 + 8'(k), 8'h80});
			n = 0;
			h = 0;
			repeat (64) step(k > 6);
			chk(32'(n), 32'(64 >> (k % 7)), "pulses");
			chk(32'(h), 32'(OH * (64 >> (k % 7))), "width");
		end
		wr(OFS_ROUTE, 32'h0000_0280);
		repeat (2) @(posedge clk_i);
		hs = 0;
		step(1'b0);
		chk(32'(hs), 32'(SH), "swpwm width");
		tally_and_finish();
	end
endmodule : tb
